// ==== logic/aofc_consts.vh ====
/*
  Constants for the output and run configuration block: register
  offsets, field positions, reset values, codes and timing counts.
  Assumes it is included by its bare name from the logic files.
*/
`ifndef AOFC_CONSTS_VH
`define AOFC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define AOFC_ADDR_W          4
`define AOFC_OFF_RUN_CFG     4'h4
`define AOFC_OFF_STATUS      4'h5
`define AOFC_OFF_RESULT0     4'h8
`define AOFC_OFF_RESULT1     4'h9
`define AOFC_OFF_RESULT2     4'hA
`define AOFC_OFF_RESULT3     4'hB
`define AOFC_OFF_CHECK0      4'hC
`define AOFC_OFF_CHECK1      4'hD
`define AOFC_OFF_CHECK2      4'hE
`define AOFC_OFF_CHECK3      4'hF
`define AOFC_OFF_POWER       4'h6
`define AOFC_OFF_CTRL        4'h7

// ----------------------------------------------------------------
// Field positions of the run configuration register
// ----------------------------------------------------------------
`define AOFC_RUN_MODE_HI     7
`define AOFC_RUN_MODE_LO     6
`define AOFC_FMT_HI          5
`define AOFC_FMT_LO          4
`define AOFC_CHK_WIDE_BIT    3
`define AOFC_CHK_EN_BIT      2
`define AOFC_OFFSET_EN_BIT   1
`define AOFC_GAIN_EN_BIT     0
`define AOFC_RUN_CFG_RESET   8'h00

// ----------------------------------------------------------------
// Codes
// ----------------------------------------------------------------
`define AOFC_MODE_CONT       2'h3
`define AOFC_MODE_STANDBY    2'h2
`define AOFC_FMT_TAG_SEXT    2'h3
`define AOFC_FMT_SEXT        2'h2
`define AOFC_FMT_LEFT        2'h1
`define AOFC_FMT_BARE        2'h0
`define AOFC_PWR_STANDBY     2'h2
`define AOFC_PWR_SHUTDOWN    2'h0
`define AOFC_PWR_CONVERT     2'h3
`define AOFC_POS_LIMIT       24'hFFFFFF
`define AOFC_NEG_LIMIT       24'h800000
`define AOFC_CRC_POLY        16'h8005

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define AOFC_CONV_CYCLES     16

`endif

// ==== logic/aofc_result_mem.v ====
/*
  Small memory holding the offset and gain correction words.
  Assumes one clock; read data come out of a register one cycle
  after the address.
*/
module aofc_result_mem #(
  parameter WIDTH = 24,
  parameter DEPTH = 2,
  parameter AW    = 1
) (
  // Clock and reset
  input  wire             clk,
  input  wire             rst_b,
  // Write port
  input  wire             wrEn,
  input  wire [AW-1:0]    wrAddr,
  input  wire [WIDTH-1:0] wrData,
  // Read port
  input  wire [AW-1:0]    rdAddr,
  output reg  [WIDTH-1:0] rdData
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  integer i;

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {WIDTH{1'b0}};
      rdData <= {WIDTH{1'b0}};
    end
    else
    begin
      if (wrEn)
        mem[wrAddr] <= wrData;
      rdData <= mem[rdAddr];
    end
  end

endmodule // aofc_result_mem

// ==== logic/aofc_output_format.v ====
/*
  Output and run configuration block of a delta-sigma converter:
  run mode sequencing, result word formatting, read checksum and
  digital offset and gain correction.
  Assumes a raw 25-bit signed modulator result on the
  clock, taken in through two sync registers with no strobe, and a register master that never waits.
*/
`include "aofc_consts.vh"
module aofc_output_format #(
  parameter CONV_CYCLES = `AOFC_CONV_CYCLES
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // Register port
  input  wire [3:0]  regAddr,
  input  wire [7:0]  regWrData,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [7:0]  regRdData,
  // Modulator side
  input  wire [24:0] rawResult,
  input  wire [3:0]  rawChannel,
  // Status and power state
  output reg  [1:0]  powerState,
  output reg         resultFresh,
  output reg         converting
);

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  reg  [7:0]  runCfg_reg;
  reg  [1:0]  power_reg;
  reg  [31:0] result_reg;
  reg  [31:0] check_reg;
  reg  [7:0]  cfgCheck_reg;
  reg         fresh_reg;
  reg  [7:0]  count_reg;
  reg         busy_reg;
  reg  [1:0]  latchMode_reg;
  reg  [1:0]  latchFmt_reg;
  reg  [23:0] calWrData_reg;
  reg  [3:0]  chanSync1_reg;
  reg  [3:0]  chanSync2_reg;
  reg  [24:0] rawSync1_reg;
  reg  [24:0] rawSync2_reg;
  reg  [1:0]  corrPhase_reg;

  wire [1:0]  runMode  = runCfg_reg[`AOFC_RUN_MODE_HI:`AOFC_RUN_MODE_LO];
  wire [1:0]  dataFmt  = runCfg_reg[`AOFC_FMT_HI:`AOFC_FMT_LO];
  wire        chkWide  = runCfg_reg[`AOFC_CHK_WIDE_BIT];
  wire        chkEn    = runCfg_reg[`AOFC_CHK_EN_BIT];
  wire        offsetEn = runCfg_reg[`AOFC_OFFSET_EN_BIT];
  wire        gainEn   = runCfg_reg[`AOFC_GAIN_EN_BIT];

  wire        wrRun    = regWr && (regAddr == `AOFC_OFF_RUN_CFG);
  wire        wrPower  = regWr && (regAddr == `AOFC_OFF_POWER);
  wire        wrCtrl   = regWr && (regAddr == `AOFC_OFF_CTRL);
  wire        startReq = wrCtrl && regWrData[0];
  // A commit stores the word held before this write's own chunk
  wire        calWr    = wrCtrl && regWrData[7];
  wire        readRes  = regRd && (regAddr[3:2] == 2'h2);

  // --------------------------------------------------------------
  // Calibration memory: word 0 offset, word 1 gain
  // --------------------------------------------------------------
  wire [23:0] calRd;
  reg  [23:0] offsetWord;
  reg  [23:0] gainWord;

  aofc_result_mem #(
    .WIDTH (24),
    .DEPTH (2),
    .AW    (1)
  ) u_cal (
    .clk    (clk),
    .rst_b  (rst_b),
    .wrEn   (calWr),
    .wrAddr (regWrData[6]),
    .wrData (calWrData_reg),
    .rdAddr (corrPhase_reg[0]),
    .rdData (calRd)
  );

  // --------------------------------------------------------------
  // Arithmetic helpers
  // --------------------------------------------------------------
  // Clip a 25-bit signed value into 24-bit code space
  // Positive overrange locks to the all-ones code
  function [23:0] clip24;
    input [24:0] v;
    begin
      if (!v[24] && v[23])
        clip24 = `AOFC_POS_LIMIT;
      else if (v[24] && !v[23])
        clip24 = `AOFC_NEG_LIMIT;
      else
        clip24 = v[23:0];
    end
  endfunction

  // One byte step of a CRC-16
  function [15:0] crcByte;
    input [15:0] c;
    input [7:0]  d;
    integer k;
    reg [15:0] t;
    begin
      t = c;
      for (k = 7; k >= 0; k = k - 1)
      begin
        if (t[15] ^ d[k])
          t = {t[14:0], 1'b0} ^ `AOFC_CRC_POLY;
        else
          t = {t[14:0], 1'b0};
      end
      crcByte = t;
    end
  endfunction

  // --------------------------------------------------------------
  // Correction path
  // --------------------------------------------------------------
  // Offset and gain taken one cycle apart from the memory
  reg  [25:0] offSum;
  reg  [49:0] gainProd;
  reg  [24:0] corrected;

  always @*
  begin
    offSum    = {rawSync2_reg[24], rawSync2_reg};
    gainProd  = 50'h0;
    corrected = rawSync2_reg;
    if (offsetEn)
      offSum = {rawSync2_reg[24], rawSync2_reg}
             + {{2{offsetWord[23]}}, offsetWord};
    if (offSum[25] != offSum[24])
      corrected = offSum[25] ? 25'h1000000 : 25'h0FFFFFF;
    else
      corrected = offSum[24:0];
    if (gainEn)
    begin
      gainProd  = $signed({{25{corrected[24]}}, corrected})
                * $signed({26'h0, gainWord});
      corrected = gainProd[47:23];
    end
  end

  // --------------------------------------------------------------
  // Result formatting
  // --------------------------------------------------------------
  reg [31:0] fmtWord;

  always @*
  begin
    case (latchFmt_reg)
      `AOFC_FMT_TAG_SEXT:
        fmtWord = {chanSync2_reg, {4{corrected[24]}},
                   corrected[23:0]};
      `AOFC_FMT_SEXT:
        fmtWord = {{8{corrected[24]}}, corrected[23:0]};
      `AOFC_FMT_LEFT:
        fmtWord = {clip24(corrected), 8'h00};
      default:
        fmtWord = {8'h00, clip24(corrected)};
    endcase
  end

  // Checksum over the four result bytes, leaving out the top byte in bare format
  reg [15:0] crcVal;

  always @*
  begin
    crcVal = 16'h0000;
    if (latchFmt_reg != `AOFC_FMT_BARE)
      crcVal = crcByte(crcVal, fmtWord[31:24]);
    crcVal = crcByte(crcVal, fmtWord[23:16]);
    crcVal = crcByte(crcVal, fmtWord[15:8]);
    crcVal = crcByte(crcVal, fmtWord[7:0]);
  end

  // --------------------------------------------------------------
  // Run sequencer
  // --------------------------------------------------------------
  // Counter is 8 bits wide: CONV_CYCLES above 256 is not supported
  localparam [7:0] LAST_COUNT = CONV_CYCLES[7:0] - 8'h01;
  wire convDone = busy_reg && (count_reg == LAST_COUNT);

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      runCfg_reg    <= `AOFC_RUN_CFG_RESET;
      power_reg     <= `AOFC_PWR_SHUTDOWN;
      result_reg    <= 32'h0;
      check_reg     <= 32'h0;
      fresh_reg     <= 1'b1;
      count_reg     <= 8'h00;
      busy_reg      <= 1'b0;
      latchMode_reg <= 2'h0;
      latchFmt_reg  <= 2'h0;
      calWrData_reg <= 24'h0;
      chanSync1_reg <= 4'h0;
      chanSync2_reg <= 4'h0;
      rawSync1_reg  <= 25'h0;
      rawSync2_reg  <= 25'h0;
      corrPhase_reg <= 2'h0;
      offsetWord    <= 24'h0;
      gainWord      <= 24'h0;
    end
    else
    begin
      // Modulator value comes from the analog domain
      rawSync1_reg  <= rawResult;
      rawSync2_reg  <= rawSync1_reg;
      chanSync1_reg <= rawChannel;
      chanSync2_reg <= chanSync1_reg;
      corrPhase_reg <= corrPhase_reg + 2'h1;
      // Memory answers one cycle late, so the odd phase
      // carries word 0 and the even phase word 1
      if (corrPhase_reg[0])
        offsetWord <= calRd;
      else
        gainWord <= calRd;
      if (wrRun)
        runCfg_reg <= regWrData;
      if (wrCtrl)
        calWrData_reg <= {regWrData[5:0], calWrData_reg[23:6]};
      if (wrPower)
        power_reg <= regWrData[1:0];
      // A start while busy is ignored
      if (!busy_reg && (startReq || power_reg == `AOFC_PWR_CONVERT))
      begin
        busy_reg      <= 1'b1;
        count_reg     <= 8'h00;
        power_reg     <= `AOFC_PWR_CONVERT;
        latchMode_reg <= runMode;
        latchFmt_reg  <= dataFmt;
      end
      else if (convDone)
      begin
        result_reg <= fmtWord;
        // Wide form pads the checksum with zeros
        check_reg  <= !chkEn ? 32'h0 :
                      chkWide ? {crcVal, 16'h0000} :
                      {16'h0000, crcVal};
        if (latchMode_reg == `AOFC_MODE_CONT)
        begin
          count_reg     <= 8'h00;
          latchMode_reg <= runMode;
          latchFmt_reg  <= dataFmt;
        end
        else
        begin
          busy_reg  <= 1'b0;
          power_reg <= (latchMode_reg == `AOFC_MODE_STANDBY) ?
                       `AOFC_PWR_STANDBY :
                       `AOFC_PWR_SHUTDOWN;
        end
      end
      else if (busy_reg)
        count_reg <= count_reg + 8'h01;
      // New data wins over a read in the same cycle
      if (convDone)
        fresh_reg <= 1'b0;
      else if (readRes)
        fresh_reg <= 1'b1;
    end
  end

  // Config checksum ignores the read checksum bits
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cfgCheck_reg <= 8'h00;
    else
      cfgCheck_reg <= {runCfg_reg[7:4], 2'b00, runCfg_reg[1:0]}
                    ^ {6'h00, power_reg};
  end

  // --------------------------------------------------------------
  // Read port and outputs
  // --------------------------------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      regRdData   <= 8'h00;
      powerState  <= `AOFC_PWR_SHUTDOWN;
      resultFresh <= 1'b1;
      converting  <= 1'b0;
    end
    else
    begin
      powerState  <= power_reg;
      resultFresh <= fresh_reg;
      converting  <= busy_reg;
      if (regRd)
      begin
        case (regAddr)
          `AOFC_OFF_RUN_CFG: regRdData <= runCfg_reg;
          `AOFC_OFF_STATUS:  regRdData <= {1'b0, fresh_reg, 5'h00,
                                           busy_reg};
          `AOFC_OFF_POWER:   regRdData <= {6'h00, power_reg};
          `AOFC_OFF_CTRL:    regRdData <= cfgCheck_reg;
          `AOFC_OFF_RESULT0: regRdData <= result_reg[31:24];
          `AOFC_OFF_RESULT1: regRdData <= result_reg[23:16];
          `AOFC_OFF_RESULT2: regRdData <= result_reg[15:8];
          `AOFC_OFF_RESULT3: regRdData <= result_reg[7:0];
          `AOFC_OFF_CHECK0:  regRdData <= check_reg[31:24];
          `AOFC_OFF_CHECK1:  regRdData <= check_reg[23:16];
          `AOFC_OFF_CHECK2:  regRdData <= check_reg[15:8];
          `AOFC_OFF_CHECK3:  regRdData <= check_reg[7:0];
          default:           regRdData <= 8'h00;
        endcase
      end
      // Idle cycles read zero, so a late sample shows no stale data
      else
        regRdData <= 8'h00;
    end
  end

endmodule // aofc_output_format

// ==== tb/aofc_output_format_chk.sv ====
/*
  Checker for the output format block, bound to its top module.
  Assumes one clock and the one-cycle register read timing.
*/
module aofc_output_format_chk #(
  parameter CONV_CYCLES = 16
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Register port
  input wire logic [3:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [7:0]  regRdData,
  // Modulator side
  input wire logic [24:0] rawResult,
  input wire logic [3:0]  rawChannel,
  // Status
  input wire logic [1:0]  powerState,
  input wire logic        resultFresh,
  input wire logic        converting
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LO = CONV_CYCLES + 1;
  localparam int HI = CONV_CYCLES + 3;
  logic [7:0] cfgShadow_reg;

  // Shadow copy, so reads can be tied to the last write
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
      cfgShadow_reg <= 8'h00;
    else if (regWr && regAddr == 4'h4)
      cfgShadow_reg <= regWrData;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ----------------------------------------------------------
  // Conversion steps
  // ----------------------------------------------------------
  sequence startSeq;
    regWr && regAddr == 4'h7 && regWrData[0] && !converting;
  endsequence
  sequence endSeq;
    $fell(converting);
  endsequence

  a_rd_idle_zero: assert property (
    regRdData != 8'h00 |-> $past(regRd))
    else $error("read data outside read cycle");
  a_cfg_readback: assert property (
    regRd && regAddr == 4'h4 |=> regRdData == cfgShadow_reg)
    else $error("config read differs from write");
  a_unmapped_zero: assert property (
    regRd && regAddr < 4'h4 |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_status_view: assert property (
    regRd && regAddr == 4'h5 |=> regRdData ==
      {1'b0, resultFresh, 5'b00000, converting})
    else $error("status read wrong");
  a_busy_span: assert property (
    startSeq |-> ##2 converting [*8])
    else $error("conversion not busy");
  a_result_time: assert property (
    startSeq |-> ##[LO:HI] !resultFresh)
    else $error("result not ready in time");
  a_standby_end: assert property (
    endSeq ##0 (cfgShadow_reg[7:6] == 2'b10) |->
      ##[0:2] powerState == 2'h2)
    else $error("one shot did not enter standby");
  a_shutdown_end: assert property (
    endSeq ##0 !cfgShadow_reg[7] |-> ##[0:2] powerState == 2'h0)
    else $error("one shot did not shut down");
  a_cont_state: assert property (
    $fell(resultFresh) && cfgShadow_reg[7:6] == 2'b11 |->
      powerState == 2'h3)
    else $error("continuous mode left converting");
  a_fresh_clear: assert property (
    regRd && regAddr[3:2] == 2'b10 && !converting &&
      powerState != 2'h3 |-> ##[1:2] resultFresh)
    else $error("result read did not clear flag");
endmodule // aofc_output_format_chk

bind aofc_output_format aofc_output_format_chk #(
  .CONV_CYCLES(CONV_CYCLES)
) chk_i (
  .clk(clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
  .regRdData(regRdData), .rawResult(rawResult),
  .rawChannel(rawChannel), .powerState(powerState),
  .resultFresh(resultFresh), .converting(converting)
);

// ==== tb/aofc_host_model.sv ====
/*
  Host model: issues single-cycle register writes and reads.
  Assumes read data stand only in the cycle after the read strobe.
*/
module aofc_host_model (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic [3:0]      regAddr,
  output logic [7:0]      regWrData,
  output logic            regWr,
  output logic            regRd,
  input  wire logic [7:0] regRdData
);
  timeunit 1ns;
  timeprecision 1ns;

  initial
  begin
    regAddr = 4'h0;
    regWrData = 8'h00;
    regWr = 1'b0;
    regRd = 1'b0;
  end

  // Data line is inverted after each write so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    regWrData <= ~d;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask
endmodule // aofc_host_model

// ==== tb/testbench.sv ====
/*
  Self-checking bench for the output format block.
  Assumes the host model for bus cycles and a 10 MHz clock.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [7:0]  cfg;
    logic [24:0] raw;
    logic [3:0]  ch;
    logic [31:0] exp;
    logic [1:0]  pwr;
  } aofc_row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [3:0]  regAddr;
  logic [7:0]  regWrData;
  logic        regWr;
  logic        regRd;
  logic [7:0]  regRdData;
  logic [24:0] rawResult = 25'h0;
  logic [3:0]  rawChannel = 4'h0;
  logic [1:0]  powerState;
  logic        resultFresh;
  logic        converting;
  int          err_total = 0;
  int          checks_done = 0;
  aofc_row_t   rows [8] = '{
    '{8'hB0, 25'h0000123, 4'h5, 32'h50000123, 2'h2},
    '{8'hB0, 25'h1FFFFFE, 4'hA, 32'hAFFFFFFE, 2'h2},
    '{8'hA0, 25'h0800000, 4'h0, 32'h00800000, 2'h2},
    '{8'hA0, 25'h1FFFFFE, 4'h0, 32'hFFFFFFFE, 2'h2},
    '{8'h90, 25'h0800000, 4'h0, 32'hFFFFFF00, 2'h2},
    '{8'h10, 25'h0123456, 4'h0, 32'h12345600, 2'h0},
    '{8'h40, 25'h17FFFFF, 4'h0, 32'h00800000, 2'h0},
    '{8'h80, 25'h1ABCDEF, 4'h0, 32'h00ABCDEF, 2'h2}};

  always #50 clk = ~clk;

  aofc_host_model aofc_host_model_i (
    .clk(clk), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));

  aofc_output_format #(.CONV_CYCLES(16)) aofc_output_format_i (
    .clk(clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rawResult(rawResult),
    .rawChannel(rawChannel), .powerState(powerState),
    .resultFresh(resultFresh), .converting(converting));

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic getWord(input logic [3:0] a, output logic [31:0] w);
    logic [7:0] b;
    w = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      aofc_host_model_i.rd(a + 4'(i), b);
      w = {w[23:0], b};
    end
  endtask

  task automatic waitFresh;
    int n;
    n = 0;
    while (resultFresh !== 1'b0 && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    chk("fresh low", 32'h0, {31'h0, resultFresh});
  endtask

  task automatic runConv(input logic [7:0] c, input logic [24:0] r,
                         input logic [3:0] t, output logic [31:0] w);
    @(posedge clk);
    rawResult <= r;
    rawChannel <= t;
    aofc_host_model_i.wr(4'h4, c);
    aofc_host_model_i.wr(4'h7, 8'h01);
    waitFresh();
    getWord(4'h8, w);
    chk("fresh high", 32'h1, {31'h0, resultFresh});
  endtask

  task automatic resetCheck;
    logic [7:0] b;
    chk("reset outputs", 32'h2,
        {28'h0, powerState, resultFresh, converting});
    aofc_host_model_i.rd(4'h4, b);
    chk("config reset", 32'h0, {24'h0, b});
    $display("test reset done");
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Run is about 520 cycles, so this only cuts a hang short
  initial
  begin
    repeat (10000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0]  b;
    logic [31:0] w;
    logic [31:0] crcN;
    logic [7:0]  b2;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    resetCheck();
    aofc_host_model_i.wr(4'h4, 8'hFF);
    aofc_host_model_i.rd(4'h4, b);
    chk("config readback", 32'hFF, {24'h0, b});
    aofc_host_model_i.wr(4'h2, 8'hFF);
    aofc_host_model_i.rd(4'h2, b);
    chk("unmapped read", 32'h0, {24'h0, b});
    aofc_host_model_i.rd(4'h5, b);
    chk("status idle", 32'h40, {24'h0, b});
    aofc_host_model_i.wr(4'h4, 8'h00);
    aofc_host_model_i.rd(4'h7, b);
    aofc_host_model_i.wr(4'h4, 8'h0C);
    aofc_host_model_i.rd(4'h7, b2);
    chk("config checksum", {24'h0, b}, {24'h0, b2});
    $display("test registers done");
    foreach (rows[i])
    begin
      runConv(rows[i].cfg, rows[i].raw, rows[i].ch, w);
      chk("result word", rows[i].exp, w);
      chk("power state", {30'h0, rows[i].pwr},
          {30'h0, powerState});
    end
    $display("test formats done");
    aofc_host_model_i.wr(4'h4, 8'h90);
    getWord(4'h8, w);
    chk("held result", 32'h00ABCDEF, w);
    runConv(8'hA4, 25'h0000456, 4'h0, w);
    getWord(4'hC, crcN);
    chk("narrow pad", 32'h0, {16'h0, crcN[31:16]});
    chk("crc present", 32'h1, {31'h0, crcN[15:0] != 16'h0});
    runConv(8'hAC, 25'h0000456, 4'h0, w);
    getWord(4'hC, w);
    chk("wide checksum", {crcN[15:0], 16'h0}, w);
    runConv(8'hA0, 25'h0000456, 4'h0, w);
    getWord(4'hC, w);
    chk("no checksum", 32'h0, w);
    $display("test checksum done");
    runConv(8'hA1, 25'h0000123, 4'h0, w);
    chk("gain zero word", 32'h0, w);
    aofc_host_model_i.wr(4'h7, 8'h10);
    for (int i = 0; i < 3; i++)
      aofc_host_model_i.wr(4'h7, 8'h00);
    aofc_host_model_i.wr(4'h7, 8'h80);
    runConv(8'hA2, 25'h0000100, 4'h0, w);
    chk("offset word", 32'h00000110, w);
    $display("test correction done");
    runConv(8'hC0, 25'h0000789, 4'h0, w);
    chk("first run word", 32'h00000789, w);
    waitFresh();
    chk("running state", 32'h3, {30'h0, powerState});
    $display("test continuous done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    resetCheck();
    tally_and_finish();
  end
endmodule // testbench
